/* File: hdl/acm_clock_config.sv */
// Audio root clock selection and microphone clock configuration block.
`timescale 1ns/100ps
module acm_clock_config (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic auto_pll_disable_i,
    input wire logic rate_family_select_i,
    input wire logic [2:0] master_clock_freq_code_i,
    input wire logic master_mode_i,
    input wire logic bclk_i,
    input wire logic master_clk_pin_i,
    input wire logic mic_data_i,
    output logic [7:0] reg_rdata_o,
    output logic root_clock_o,
    output logic root_from_master_o,
    output logic master_clock_freq_mode_o,
    output logic [14:0] master_clock_khz_o,
    output logic [11:0] master_clock_ratio_o,
    output logic frame_sync_bclk_o,
    output logic mic_clock_o,
    output acm_pkg::acm_mic_pair_t mic_pair_o,
    output logic mic_ch1_valid_o,
    output logic mic_ch2_valid_o
);
    logic [7:0] clock_source_config_reg;
    logic [7:0] mic_div_reg;
    logic [7:0] mic_edge_reg;
    acm_pkg::acm_cfg_t cfg;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic bclk_s;
    logic mclk_s;
    logic data_s;
    logic [6:0] half;
    logic mic_clk;
    logic mic_rise;
    logic mic_fall;
    logic root_sel_eff;

    assign cfg = '{root_sel: clock_source_config_reg[acm_pkg::ROOT_SEL_BIT],
                   freq_mode: clock_source_config_reg[acm_pkg::FREQ_MODE_BIT],
                   ratio_code: clock_source_config_reg[acm_pkg::RATIO_LSB +: 3],
                   invert: clock_source_config_reg[acm_pkg::INVERT_BIT],
                   mic_div: mic_div_reg[acm_pkg::DIV_LSB +: 2],
                   edge_swap: mic_edge_reg[acm_pkg::EDGE_BIT]};
    assign bclk_s = pin_sync_reg[0];
    assign mclk_s = pin_sync_reg[1];
    assign data_s = pin_sync_reg[2];

    // Two-stage synchronisers for the pin inputs.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= (gi == 0) ? bclk_i : (gi == 1) ? master_clk_pin_i : mic_data_i;
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    // Register writes at the documented offsets.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            clock_source_config_reg <= acm_pkg::CLOCK_SOURCE_CONFIG_RESET;
            mic_div_reg <= acm_pkg::MIC_DIV_RESET;
            mic_edge_reg <= acm_pkg::MIC_EDGE_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == acm_pkg::CLOCK_SOURCE_CONFIG_OFFS) begin
                clock_source_config_reg <= reg_wdata_i;
            end
            if (reg_addr_i == acm_pkg::MIC_DIV_OFFS) begin
                mic_div_reg <= reg_wdata_i;
            end
            if (reg_addr_i == acm_pkg::MIC_EDGE_OFFS) begin
                mic_edge_reg <= reg_wdata_i & acm_pkg::MIC_EDGE_RW_MASK;
            end
        end
    end

    // Register reads, unmapped offsets return zero.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                acm_pkg::CLOCK_SOURCE_CONFIG_OFFS: reg_rdata_o <= clock_source_config_reg;
                acm_pkg::MIC_DIV_OFFS: reg_rdata_o <= mic_div_reg;
                acm_pkg::MIC_EDGE_OFFS: reg_rdata_o <= mic_edge_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    assign root_sel_eff = auto_pll_disable_i & cfg.root_sel;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            root_clock_o <= 1'b0;
            root_from_master_o <= 1'b0;
        end else begin
            root_from_master_o <= root_sel_eff;
            root_clock_o <= root_sel_eff ? mclk_s : bclk_s;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            master_clock_freq_mode_o <= 1'b0;
            master_clock_khz_o <= 15'h0000;
            master_clock_ratio_o <= 12'h000;
        end else begin
            master_clock_freq_mode_o <= cfg.freq_mode;
            master_clock_khz_o <= cfg.freq_mode ? 15'h0000
                                  : acm_pkg::freq_khz_decode(master_clock_freq_code_i);
            master_clock_ratio_o <= (cfg.freq_mode | root_sel_eff | master_mode_i)
                                    ? acm_pkg::ratio_decode(cfg.ratio_code) : 12'h000;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            frame_sync_bclk_o <= 1'b0;
        end else begin
            frame_sync_bclk_o <= bclk_s ^ (master_mode_i & cfg.invert);
        end
    end

    assign half = acm_pkg::mic_half_decode(cfg.mic_div, rate_family_select_i);

    acm_mic_clk_gen u_mic_clk (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .half_i(half),
        .mic_clock_o(mic_clk),
        .rise_o(mic_rise),
        .fall_o(mic_fall)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mic_clock_o <= 1'b0;
        end else begin
            mic_clock_o <= mic_clk;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mic_pair_o <= '0;
            mic_ch1_valid_o <= 1'b0;
            mic_ch2_valid_o <= 1'b0;
        end else begin
            mic_ch1_valid_o <= cfg.edge_swap ? mic_rise : mic_fall;
            mic_ch2_valid_o <= cfg.edge_swap ? mic_fall : mic_rise;
            if (cfg.edge_swap ? mic_rise : mic_fall) begin
                mic_pair_o.ch1 <= data_s;
            end
            if (cfg.edge_swap ? mic_fall : mic_rise) begin
                mic_pair_o.ch2 <= data_s;
            end
        end
    end

    property p_clock_source_config_write;
        @(posedge mclk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == acm_pkg::CLOCK_SOURCE_CONFIG_OFFS) ##1 (reg_rd_i && reg_addr_i
            == acm_pkg::CLOCK_SOURCE_CONFIG_OFFS && !reg_wr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_clock_source_config_write: assert property (p_clock_source_config_write) else $error("clock source readback");

    property p_edge_rsv_zero;
        @(posedge mclk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == acm_pkg::MIC_EDGE_OFFS) |=> reg_rdata_o[5:0] == 6'h00;
    endproperty
    a_edge_rsv_zero: assert property (p_edge_rsv_zero) else $error("reserved bits not zero");

    property p_root_select;
        @(posedge mclk_i) disable iff (rst_i)
        ##1 root_clock_o == ($past(auto_pll_disable_i && clock_source_config_reg[7]) ? $past(mclk_s)
            : $past(bclk_s));
    endproperty
    a_root_select: assert property (p_root_select) else $error("root clock source wrong");

    property p_ratio_top;
        @(posedge mclk_i) disable iff (rst_i)
        (clock_source_config_reg[5:3] == 3'h7 && clock_source_config_reg[6]) |=> master_clock_ratio_o == 12'h900;
    endproperty
    a_ratio_top: assert property (p_ratio_top) else $error("ratio 2304 not decoded");

    property p_freq_code;
        @(posedge mclk_i) disable iff (rst_i)
        (!clock_source_config_reg[6] && master_clock_freq_code_i == 3'h0) |=> master_clock_khz_o == 15'h2EE0;
    endproperty
    a_freq_code: assert property (p_freq_code) else $error("12 MHz code wrong");

    property p_invert;
        @(posedge mclk_i) disable iff (rst_i)
        (master_mode_i && clock_source_config_reg[1]) |=> frame_sync_bclk_o != $past(bclk_s);
    endproperty
    a_invert: assert property (p_invert) else $error("frame sync clock not inverted");

    property p_mic_div3;
        @(posedge mclk_i) disable iff (rst_i)
        (mic_div_reg[1:0] == 2'h3 && !rate_family_select_i) |-> half == 7'h08;
    endproperty
    a_mic_div3: assert property (p_mic_div3) else $error("6.144 MHz divider wrong");

    property p_mic_div0_44;
        @(posedge mclk_i) disable iff (rst_i)
        (mic_div_reg[1:0] == 2'h0 && rate_family_select_i) |-> half == 7'h11;
    endproperty
    a_mic_div0_44: assert property (p_mic_div0_44) else $error("2.8224 MHz divider wrong");

    property p_ch1_fall;
        @(posedge mclk_i) disable iff (rst_i)
        (!mic_edge_reg[7] && mic_fall) |=> mic_ch1_valid_o && mic_pair_o.ch1 == $past(data_s)
            && !mic_clock_o ##0 !mic_ch2_valid_o;
    endproperty
    a_ch1_fall: assert property (p_ch1_fall) else $error("channel 1 edge wrong");

    c_swap: cover property (@(posedge mclk_i) disable iff (rst_i) mic_edge_reg[7] && mic_rise);
    c_root_master: cover property (@(posedge mclk_i) disable iff (rst_i) root_from_master_o);
    c_div3: cover property (@(posedge mclk_i) disable iff (rst_i) mic_div_reg[1:0] == 2'h3);
    c_invert: cover property (@(posedge mclk_i) disable iff (rst_i) master_mode_i && cfg.invert);
endmodule : acm_clock_config

/* File: hdl/acm_pkg.sv */
// Shared constants, types and decoders for the audio clock and microphone configuration block.
package acm_pkg;

    localparam logic [7:0] CLOCK_SOURCE_CONFIG_OFFS = 8'h16;
    localparam logic [7:0] MIC_DIV_OFFS = 8'h1F;
    localparam logic [7:0] MIC_EDGE_OFFS = 8'h20;

    localparam logic [7:0] CLOCK_SOURCE_CONFIG_RESET = 8'h10;
    localparam logic [7:0] MIC_DIV_RESET = 8'h40;
    localparam logic [7:0] MIC_EDGE_RESET = 8'h00;

    localparam int ROOT_SEL_BIT = 7;
    localparam int FREQ_MODE_BIT = 6;
    localparam int RATIO_LSB = 3;
    localparam int INVERT_BIT = 1;
    localparam int DIV_LSB = 0;
    localparam int EDGE_BIT = 7;
    localparam logic [7:0] MIC_EDGE_RW_MASK = 8'hC0;

    localparam longint CLK_HZ = 100_000_000;
    localparam longint MIC_F48_DIV0_HZ = 3_072_000;
    localparam longint MIC_F48_DIV1_HZ = 1_536_000;
    localparam longint MIC_F48_DIV2_HZ = 768_000;
    localparam longint MIC_F48_DIV3_HZ = 6_144_000;
    localparam longint MIC_F44_DIV0_HZ = 2_822_400;
    localparam longint MIC_F44_DIV1_HZ = 1_411_200;
    localparam longint MIC_F44_DIV2_HZ = 705_600;
    localparam longint MIC_F44_DIV3_HZ = 5_644_800;

    // Half periods of the microphone clock in system cycles, rounded down.
    localparam logic [6:0] HALF_48_DIV0 = 7'(CLK_HZ / (2 * MIC_F48_DIV0_HZ));
    localparam logic [6:0] HALF_48_DIV1 = 7'(CLK_HZ / (2 * MIC_F48_DIV1_HZ));
    localparam logic [6:0] HALF_48_DIV2 = 7'(CLK_HZ / (2 * MIC_F48_DIV2_HZ));
    localparam logic [6:0] HALF_48_DIV3 = 7'(CLK_HZ / (2 * MIC_F48_DIV3_HZ));
    localparam logic [6:0] HALF_44_DIV0 = 7'(CLK_HZ / (2 * MIC_F44_DIV0_HZ));
    localparam logic [6:0] HALF_44_DIV1 = 7'(CLK_HZ / (2 * MIC_F44_DIV1_HZ));
    localparam logic [6:0] HALF_44_DIV2 = 7'(CLK_HZ / (2 * MIC_F44_DIV2_HZ));
    localparam logic [6:0] HALF_44_DIV3 = 7'(CLK_HZ / (2 * MIC_F44_DIV3_HZ));

    typedef struct packed {
        logic root_sel;
        logic freq_mode;
        logic [2:0] ratio_code;
        logic invert;
        logic [1:0] mic_div;
        logic edge_swap;
    } acm_cfg_t;

    typedef struct packed {
        logic ch1;
        logic ch2;
    } acm_mic_pair_t;

    function automatic logic [11:0] ratio_decode(input logic [2:0] code);
        case (code)
            3'h0: ratio_decode = 12'h040;
            3'h1: ratio_decode = 12'h100;
            3'h2: ratio_decode = 12'h180;
            3'h3: ratio_decode = 12'h200;
            3'h4: ratio_decode = 12'h300;
            3'h5: ratio_decode = 12'h400;
            3'h6: ratio_decode = 12'h600;
            default: ratio_decode = 12'h900;
        endcase
    endfunction : ratio_decode

    function automatic logic [14:0] freq_khz_decode(input logic [2:0] code);
        case (code)
            3'h0: freq_khz_decode = 15'h2EE0;
            3'h1: freq_khz_decode = 15'h3000;
            3'h2: freq_khz_decode = 15'h32C8;
            3'h3: freq_khz_decode = 15'h3E80;
            3'h4: freq_khz_decode = 15'h4B00;
            3'h5: freq_khz_decode = 15'h4CE0;
            3'h6: freq_khz_decode = 15'h5DC0;
            default: freq_khz_decode = 15'h6000;
        endcase
    endfunction : freq_khz_decode

    function automatic logic [6:0] mic_half_decode(input logic [1:0] div, input logic fam44);
        case ({fam44, div})
            3'h0: mic_half_decode = HALF_48_DIV0;
            3'h1: mic_half_decode = HALF_48_DIV1;
            3'h2: mic_half_decode = HALF_48_DIV2;
            3'h3: mic_half_decode = HALF_48_DIV3;
            3'h4: mic_half_decode = HALF_44_DIV0;
            3'h5: mic_half_decode = HALF_44_DIV1;
            3'h6: mic_half_decode = HALF_44_DIV2;
            default: mic_half_decode = HALF_44_DIV3;
        endcase
    endfunction : mic_half_decode

endpackage : acm_pkg

/* File: hdl/acm_mic_clk_gen.sv */
// Microphone clock divider with edge pulses.
`timescale 1ns/100ps
module acm_mic_clk_gen (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [6:0] half_i,
    output logic mic_clock_o,
    output logic rise_o,
    output logic fall_o
);
    logic [6:0] cnt_reg;
    logic last;

    assign last = (cnt_reg >= half_i - 7'h01);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_reg <= 7'h00;
        end else if (last) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mic_clock_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= last & ~mic_clock_o;
            fall_o <= last & mic_clock_o;
            if (last) begin
                mic_clock_o <= ~mic_clock_o;
            end
        end
    end
endmodule : acm_mic_clk_gen

/* File: verification/acm_mic_model.sv */
// Behavioural pair of microphones sharing one clock and data line.
`timescale 1ns/100ps
module acm_mic_model (
    input wire logic mic_clock_i,
    input wire logic swap_i,
    input wire logic ch1_bit_i,
    input wire logic ch2_bit_i,
    output logic mic_data_o
);
    initial mic_data_o = 1'b0;
    always @(mic_clock_i) begin
        if (mic_clock_i ^ swap_i) begin
            mic_data_o <= ch1_bit_i;
        end else begin
            mic_data_o <= ch2_bit_i;
        end
    end
endmodule : acm_mic_model

/* File: verification/tb_acm_clock_config.sv */
// Self-checking bench for the audio clock and microphone configuration block.
`timescale 1ns/100ps
module tb_acm_clock_config;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic apd = 1'b0;
    logic fam = 1'b0;
    logic [2:0] fcode = 3'h0;
    logic mm = 1'b0;
    logic bclk = 1'b0;
    logic mpin = 1'b0;
    logic swap = 1'b0;
    logic b1 = 1'b0;
    logic b2 = 1'b0;
    logic mchk = 1'b0;
    logic rd_d = 1'b0;
    logic mdata, root, from_m, fmode, fsb, mic_clk, v1, v2;
    logic [7:0] rdata;
    logic [14:0] khz;
    logic [11:0] ratio;
    acm_pkg::acm_mic_pair_t pair;
    logic [7:0] exp_q[$];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int ratios[8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
    int khzs[8] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
    int halves[8] = '{16, 32, 65, 8, 17, 35, 70, 8};

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    acm_clock_config acm_clock_config_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .auto_pll_disable_i(apd), .rate_family_select_i(fam),
        .master_clock_freq_code_i(fcode), .master_mode_i(mm), .bclk_i(bclk),
        .master_clk_pin_i(mpin), .mic_data_i(mdata), .reg_rdata_o(rdata),
        .root_clock_o(root), .root_from_master_o(from_m),
        .master_clock_freq_mode_o(fmode), .master_clock_khz_o(khz),
        .master_clock_ratio_o(ratio), .frame_sync_bclk_o(fsb),
        .mic_clock_o(mic_clk), .mic_pair_o(pair), .mic_ch1_valid_o(v1),
        .mic_ch2_valid_o(v2));

    acm_mic_model acm_mic_model_inst (.mic_clock_i(mic_clk), .swap_i(swap),
        .ch1_bit_i(b1), .ch2_bit_i(b2), .mic_data_o(mdata));

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wt

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_i);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge mclk_i);
        rd = 1'b0;
    endtask : rd_reg

    // Write followed by a read of the same offset in the very next cycle.
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
        rd = 1'b1;
        exp_q.push_back(d);
        @(negedge mclk_i);
        rd = 1'b0;
    endtask : wr_rd

    task automatic half_chk(input int e);
        int n;
        logic last;
        wt(300);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            last = mic_clk;
            while (mic_clk === last && n < 300) begin
                @(negedge mclk_i);
                n++;
            end
        end
        chk(n, e);
    endtask : half_chk

    always @(posedge mclk_i) begin
        rd_d <= rd;
        cyc <= cyc + 1;
    end

    // Watcher compares read data with the oldest note and the latched mic bits.
    always @(negedge mclk_i) begin
        if (rd_d === 1'b1) begin
            chk(rdata, exp_q.pop_front());
        end
        if (mchk && v1 === 1'b1) begin
            chk(pair.ch1, b1);
        end
        if (mchk && v2 === 1'b1) begin
            chk(pair.ch2, b2);
        end
        if (cyc > 60000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h782e));
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_i = 1'b0;
        rd_reg(8'h16, 8'h10);
        rd_reg(8'h1F, 8'h40);
        rd_reg(8'h20, 8'h00);
        rd_reg(8'h17, 8'h00);
        wr_reg(8'h20, 8'hBF);
        rd_reg(8'h20, 8'h80);
        // reserved bits kept at reset value
        for (int i = 0; i < 4; i++) begin
            wdata = 8'($urandom) & 8'hFA;
            wr_rd(8'h16, wdata);
        end
        for (int a = 0; a < 2; a++) begin
            for (int s = 0; s < 2; s++) begin
                apd = a[0];
                mpin = 1'b1;
                wr_reg(8'h16, {s[0], 7'h10});
                wt(5);
                chk(from_m, a & s);
                chk(root, a & s);
            end
        end
        mm = 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr_reg(8'h16, {2'b01, c[2:0], 3'b000});
            wt(2);
            chk(ratio, ratios[c]);
            chk(fmode, 1);
            chk(khz, 0);
            fcode = c[2:0];
            wr_reg(8'h16, 8'h10);
            wt(2);
            chk(khz, khzs[c]);
        end
        for (int m = 0; m < 2; m++) begin
            for (int v = 0; v < 2; v++) begin
                mm = m[0];
                bclk = 1'($urandom);
                wr_reg(8'h16, {6'h04, v[0], 1'b0});
                wt(5);
                chk(fsb, bclk ^ (m & v));
            end
        end
        // only channels 1 and 2 are in use
        for (int f = 0; f < 2; f++) begin
            for (int d = 0; d < 4; d++) begin
                fam = f[0];
                wr_reg(8'h1F, {6'h10, d[1:0]});
                half_chk(halves[f * 4 + d]);
            end
        end
        for (int s = 0; s < 2; s++) begin
            mchk = 1'b0;
            wr_reg(8'h20, {s[0], 7'h00});
            swap = s[0];
            b1 = 1'($urandom);
            b2 = ~b1;
            wt(100);
            mchk = 1'b1;
            wt(300);
        end
        mchk = 1'b0;
        wt(5);
        // A second reset in mid-run restores the register defaults.
        rst_i = 1'b1;
        wt(3);
        rst_i = 1'b0;
        rd_reg(8'h16, 8'h10);
        rd_reg(8'h20, 8'h00);
        finish_test();
    end
endmodule : tb_acm_clock_config
